// *** common/iss_map.vh ***
`ifndef ISS_MAP_VH
`define ISS_MAP_VH
// register byte offsets (word aligned)
`define ISS_STBY_CTRL_OFS 4'h0
`define ISS_STBY_MODE_OFS 4'h4
`define ISS_STAB_SEL_OFS 4'h8
`define ISS_STATUS_OFS 4'hc
`define ISS_PROTECT_OFS 5'h10
// standby control fields
`define ISS_CTRL_REQ_BIT 1
`define ISS_CTRL_BLOCK_BIT 4
`define ISS_MODE_DEEP_BIT 0
// stabilization select field
`define ISS_STAB_SEL_W 3
`define ISS_STAB_SEL_RST 3'h4
// shortest wait exponent; select value n gives 2^(base+n) periods
`define ISS_STAB_BASE 5'd12
// reset wait exponent: 2^16 periods
`define ISS_STAB_RST_EXP 5'd16
// unlock key for the write-protect command register
`define ISS_PROTECT_KEY 8'ha5
// wake cause codes in status
`define ISS_CAUSE_NONE 2'h0
`define ISS_CAUSE_IRQ 2'h1
`define ISS_CAUSE_RST 2'h2
`endif

// *** rtl/iss_standby_ctrl.v ***
// Contract
// - deep select 0 plus request enters idle
// - idle keeps oscillator, gates cpu and peripherals
// - idle release returns without stabilization wait
// - idle wakes on unmasked irqs or resets
// - maskable wake block stops irq release
// - low priority wake leaves request pending
// - higher priority wake branches to handler
// - interrupts disabled resume at next instruction
// - reset wake performs full reset sequence
// - standby stops clocks except slave serial
// - detector and power-on clear keep running
// - ports, cpu state, ram are held
// - deep select 1 plus request enters stop
// - stop halts oscillator, pll and clocks
// - stop wakes on unmasked irqs or resets
// - stop resumes only after stabilization wait
// - stop halts clock monitor, internal osc runs
// - irq wake uses select, reset uses 2^16
// - wait counted by watchdog timer counter
// - deep select only valid with request
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "iss_map.vh"
module iss_standby_ctrl #(
	// counter width; must stay above the largest wait exponent, 19
	parameter WDT_W = 20
) (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [4:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// wake sources from pins and analog blocks
	input wire [5:0] externalIrqPins,
	input wire lowVoltageIrq,
	input wire serialSlaveIrq,
	input wire resetPin_n,
	input wire lowVoltageReset,
	input wire powerOnClearReset,
	// interrupt controller side
	input wire [5:0] irqMask,
	input wire irqEnable,
	input wire wakeHigherPrio,
	input wire lowVoltageDetectorUsed,
	// clock and core controls
	output reg cpuClkEn,
	output reg periphClkEn,
	output reg oscEn,
	output reg pllEn,
	output reg clkMonEn,
	output reg intOscEn,
	output reg serialSlaveClkEn,
	output reg lowVoltageDetectorEn,
	output reg powerOnClearEn,
	output reg holdState,
	output reg sysReset,
	output reg wakeBranch,
	output reg wakeResume,
	output reg wdtCountEn
);
	// one-hot states; status reads this code as is
	localparam ST_RUN = 5'h01;
	localparam ST_IDLE = 5'h02;
	localparam ST_STOP = 5'h04;
	localparam ST_STAB = 5'h08;
	localparam ST_RST = 5'h10;

	// two-flop synchronisers for outside inputs
	// reset pin is inverted first so every line is active high
	reg [10:0] syncA_q;
	reg [10:0] syncB_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q <= 11'h000;
			syncB_q <= 11'h000;
		end else begin
			syncA_q <= {externalIrqPins, lowVoltageIrq, serialSlaveIrq,
				~resetPin_n, lowVoltageReset, powerOnClearReset};
			syncB_q <= syncA_q;
		end
	end

	// synchronised wake lines
	wire [5:0] extPins = syncB_q[10:5];
	wire lvIrq = syncB_q[4];
	wire csIrq = syncB_q[3];

	// reset-class sources
	wire anyReset = |syncB_q[2:0];

	// pins pass only where their mask bit is clear
	wire pinWake = |(extPins & ~irqMask);
	// low-voltage and serial requests have no mask of their own here
	// unmasked maskable wake, gated by block bit
	wire maskWake;
	reg block_q;
	assign maskWake = ~block_q &
		(pinWake | lvIrq | csIrq);

	reg [4:0] state_q;
	reg [4:0] state_d;
	reg req_q;
	reg deep_q;
	reg [`ISS_STAB_SEL_W-1:0] stabSel_q;
	reg unlock_q;
	reg [1:0] cause_q;
	reg [1:0] cause_d;
	reg [WDT_W-1:0] wdt_q;
	reg fromReset_q;

	// state decode shared by the register and counter processes
	wire inRun = state_q == ST_RUN;
	wire inStab = state_q == ST_STAB;
	wire toReset = state_q == ST_RST || state_d == ST_RST;
	wire leaving = state_q != ST_RUN && state_d != state_q;

	// bus decode
	// only lane 0 holds register bits, upper lanes are ignored
	// a request counts once: ack high masks it for the next edge
	wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wbWr = wbReq & wb_we_i & wb_sel_i[0];
	wire selCtrl = wb_adr_i == {1'b0, `ISS_STBY_CTRL_OFS};
	wire selMode = wb_adr_i == {1'b0, `ISS_STBY_MODE_OFS};
	wire selStab = wb_adr_i == {1'b0, `ISS_STAB_SEL_OFS};
	wire selStat = wb_adr_i == {1'b0, `ISS_STATUS_OFS};
	wire selProt = wb_adr_i == `ISS_PROTECT_OFS;
	// control write takes effect only right after the unlock key
	wire ctrlWr = wbWr & selCtrl & unlock_q;
	wire enterReq = ctrlWr & wb_dat_i[`ISS_CTRL_REQ_BIT];

	// wait exponent: select register or reset default
	// a reset wake ignores the select value, it was just reset anyway
	wire [4:0] expo = fromReset_q ? `ISS_STAB_RST_EXP :
		(`ISS_STAB_BASE + {2'b00, stabSel_q});
	// counter bit expo rises after exactly 2^expo counted periods
	// so the wait is the watchdog counter's overflow interval
	wire wdtOvf = wdt_q[expo];

	// standby state machine
	// run goes to idle or stop on the request, chosen by the deep bit
	// idle returns straight to run; stop goes through the timed wait
	// any reset source goes to the reset state, then a fixed wait
	// the core's pending request is not cleared here, the core keeps it
	// priority is judged by the core; this block only picks the exit
	always @* begin
		state_d = state_q;
		cause_d = cause_q;
		case (state_q)
			ST_RUN: begin
				if (anyReset) begin
					state_d = ST_RST;
					cause_d = `ISS_CAUSE_RST;
				end else if (req_q && deep_q)
					state_d = ST_STOP;
				else if (req_q)
					state_d = ST_IDLE;
			end
			ST_IDLE: begin
				if (anyReset) begin
					state_d = ST_RST;
					cause_d = `ISS_CAUSE_RST;
				end else if (maskWake) begin
					state_d = ST_RUN;
					cause_d = `ISS_CAUSE_IRQ;
				end
			end
			ST_STOP: begin
				if (anyReset) begin
					state_d = ST_RST;
					cause_d = `ISS_CAUSE_RST;
				end else if (maskWake) begin
					state_d = ST_STAB;
					cause_d = `ISS_CAUSE_IRQ;
				end
			end
			ST_STAB: begin
				// a reset source still wins during the wait
				if (anyReset)
					state_d = ST_RST;
				else if (wdtOvf)
					state_d = ST_RUN;
			end
			ST_RST: begin
				// reset holds until all sources drop, then reset wait
				if (!anyReset)
					state_d = ST_STAB;
			end
			// an illegal code falls back to run
			default: state_d = ST_RUN;
		endcase
	end

	// state and wake cause
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_RUN;
			cause_q <= `ISS_CAUSE_NONE;
		end else begin
			state_q <= state_d;
			cause_q <= cause_d;
		end
	end

	// unlock flag; any bus write with lane 0 selected after the key relocks
	// so the key and the control write must come back to back
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			unlock_q <= 1'b0;
		else if (wbWr)
			unlock_q <= selProt &&
				wb_dat_i[7:0] == `ISS_PROTECT_KEY;
	end

	// software registers; a reset source puts them back to defaults
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			req_q <= 1'b0;
			deep_q <= 1'b0;
			block_q <= 1'b0;
			stabSel_q <= `ISS_STAB_SEL_RST;
			fromReset_q <= 1'b0;
		end else if (toReset) begin
			req_q <= 1'b0;
			deep_q <= 1'b0;
			block_q <= 1'b0;
			stabSel_q <= `ISS_STAB_SEL_RST;
			fromReset_q <= 1'b1;
		end else begin
			// leaving standby drops the request
			if (leaving)
				req_q <= 1'b0;
			else if (ctrlWr && inRun)
				req_q <= enterReq;
			if (ctrlWr)
				block_q <= wb_dat_i[`ISS_CTRL_BLOCK_BIT];
			if (wbWr && selMode)
				deep_q <= wb_dat_i[`ISS_MODE_DEEP_BIT];
			if (wbWr && selStab)
				stabSel_q <= wb_dat_i[`ISS_STAB_SEL_W-1:0];
			if (inStab && wdtOvf)
				fromReset_q <= 1'b0;
		end
	end

	// wait counter, the watchdog count; held at zero outside the wait
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			wdt_q <= {WDT_W{1'b0}};
		else if (inStab && !wdtOvf)
			wdt_q <= wdt_q + {{(WDT_W-1){1'b0}}, 1'b1};
		else
			wdt_q <= {WDT_W{1'b0}};
	end

	// read-back words, unused bits read zero
	wire [31:0] ctrlWord = {27'h0, block_q, 2'b00, req_q, 1'b0};
	wire [31:0] modeWord = {31'h0, deep_q};
	wire [31:0] stabWord = {29'h0, stabSel_q};
	wire [31:0] statWord = {25'h0, cause_q, state_q};

	// read mux; unmapped words read zero
	// address decode reuses the bus select wires
	reg [31:0] rdData;
	always @* begin
		rdData = 32'h0000_0000;
		if (selCtrl)
			rdData = ctrlWord;
		else if (selMode)
			rdData = modeWord;
		else if (selStab)
			rdData = stabWord;
		else if (selStat)
			rdData = statWord;
	end

	// bus answer: exactly one wait state
	// ack never stands two cycles, so one request is one transfer
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wbReq;
	end

	// read data stands with ack only, zero otherwise
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			wb_dat_o <= 32'h0000_0000;
		else if (wbReq)
			wb_dat_o <= rdData;
		else
			wb_dat_o <= 32'h0000_0000;
	end

	// an interrupt wake that lands back in run this cycle
	wire irqReturn = state_d == ST_RUN && state_q != ST_RUN &&
		cause_d == `ISS_CAUSE_IRQ && !fromReset_q;
	// the core judges priority, so it also says which way to go
	wire takeBranch = irqEnable && wakeHigherPrio;

	// cpu and peripheral clocks, only in normal run
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpuClkEn <= 1'b0;
			periphClkEn <= 1'b0;
		end else begin
			cpuClkEn <= state_d == ST_RUN;
			periphClkEn <= state_d == ST_RUN;
		end
	end

	// oscillator, pll and clock monitor off in stop only
	// internal oscillator never stops, it is not ours to gate
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			oscEn <= 1'b1;
			pllEn <= 1'b1;
			clkMonEn <= 1'b1;
			intOscEn <= 1'b1;
		end else begin
			oscEn <= state_d != ST_STOP;
			pllEn <= state_d != ST_STOP;
			clkMonEn <= state_d != ST_STOP;
			intOscEn <= 1'b1;
		end
	end

	// blocks that stay powered through every standby mode
	// the detector follows its use bit one cycle late
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			serialSlaveClkEn <= 1'b1;
			lowVoltageDetectorEn <= 1'b0;
			powerOnClearEn <= 1'b1;
		end else begin
			serialSlaveClkEn <= 1'b1; // slave only
			lowVoltageDetectorEn <= lowVoltageDetectorUsed;
			powerOnClearEn <= 1'b1;
		end
	end

	// freeze, system reset and wait counting
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			holdState <= 1'b0;
			sysReset <= 1'b1;
			wdtCountEn <= 1'b0;
		end else begin
			// ports, core state and ram frozen while standing by
			holdState <= state_d == ST_IDLE || state_d == ST_STOP ||
				(state_d == ST_STAB && !fromReset_q);
			sysReset <= state_d == ST_RST ||
				(state_d == ST_STAB && fromReset_q);
			wdtCountEn <= state_d == ST_STAB;
		end
	end

	// one-cycle pulses on return to run after an interrupt wake
	// the core's priority answer is taken at the wake edge itself
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wakeBranch <= 1'b0;
			wakeResume <= 1'b0;
		end else begin
			wakeBranch <= irqReturn && takeBranch;
			wakeResume <= irqReturn && !takeBranch;
		end
	end
endmodule

// *** tb/iss_standby_asserts.sv ***
`timescale 1ns/10ps
module iss_standby_asserts (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	// controls watched
	input wire lowVoltageDetectorUsed,
	input wire cpuClkEn,
	input wire periphClkEn,
	input wire oscEn,
	input wire pllEn,
	input wire clkMonEn,
	input wire intOscEn,
	input wire serialSlaveClkEn,
	input wire lowVoltageDetectorEn,
	input wire powerOnClearEn,
	input wire holdState,
	input wire sysReset,
	input wire wakeBranch,
	input wire wakeResume,
	input wire wdtCountEn
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// standby and wait states never clock the core
	a_hold_gates: assert property (holdState |-> !cpuClkEn && !periphClkEn)
		else $error("clock on while held");
	a_stop_halts: assert property (!oscEn |-> !pllEn && !clkMonEn && !cpuClkEn)
		else $error("stop left a clock running");
	a_idle_resume: assert property ($fell(holdState) && !sysReset |-> cpuClkEn && !wdtCountEn)
		else $error("resume without core clock");
	a_lvd_follow: assert property ($changed(lowVoltageDetectorUsed) |=> lowVoltageDetectorEn == $past(lowVoltageDetectorUsed))
		else $error("detector enable wrong");
	a_reset_gates: assert property (sysReset |-> !cpuClkEn && !wakeBranch && !wakeResume)
		else $error("core active in reset");
	a_always_on: assert property (powerOnClearEn && intOscEn && serialSlaveClkEn)
		else $error("always-on block stopped");
	a_wait_gated: assert property (wdtCountEn |-> oscEn && !cpuClkEn && !periphClkEn)
		else $error("wait with core clock");
	a_branch_pulse: assert property (wakeBranch |-> !wakeResume ##1 !wakeBranch)
		else $error("branch pulse wrong");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	c_stop: cover property ($fell(oscEn));
	c_branch: cover property (wakeBranch);
	c_resume: cover property (wakeResume);
	c_wait: cover property ($rose(wdtCountEn));
endmodule
bind iss_standby_ctrl iss_standby_asserts chk_u (.*);

// *** tb/iss_cpu_model.sv ***
`timescale 1ns/10ps
module iss_cpu_model (
	// clock and reset
	input wire mclk,
	input wire rst_n,
	// bench setting {prio, enable, mask}
	input wire [7:0] cfg,
	// controller side
	input wire wakeBranch,
	input wire wakeResume,
	output reg [5:0] irqMask,
	output reg irqEnable,
	output reg wakeHigherPrio,
	// outcomes seen by the core
	output reg [7:0] branchCnt,
	output reg [7:0] resumeCnt
);
	// settings change only on the clock, like the real controller
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{wakeHigherPrio, irqEnable, irqMask} <= 8'h3f;
			branchCnt <= 8'h00;
			resumeCnt <= 8'h00;
		end else begin
			{wakeHigherPrio, irqEnable, irqMask} <= cfg;
			branchCnt <= branchCnt + {7'h00, wakeBranch};
			resumeCnt <= resumeCnt + {7'h00, wakeResume};
		end
	end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
`include "iss_map.vh"
module tb;
	logic mclk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
	logic [5:0] externalIrqPins = 6'h00, irqMask;
	logic lowVoltageIrq = 0, serialSlaveIrq = 0, resetPin_n = 1;
	logic lowVoltageReset = 0, powerOnClearReset = 0;
	logic lowVoltageDetectorUsed = 1, irqEnable, wakeHigherPrio, wb_ack_o;
	logic cpuClkEn, periphClkEn, oscEn, pllEn, clkMonEn, intOscEn;
	logic serialSlaveClkEn, lowVoltageDetectorEn, powerOnClearEn;
	logic holdState, sysReset, wakeBranch, wakeResume, wdtCountEn;
	logic [7:0] cfg = 8'h3f, branchCnt, resumeCnt;
	int miscompares = 0, checkCount = 0, cycN = 0, n;
	iss_standby_ctrl dut_u (.*);
	iss_cpu_model cpu_u (.*);
	initial forever #4 mclk = ~mclk;
	// hang guard, well above the 65536-cycle reset wait
	always @(posedge mclk) begin
		cycN++;
		if (cycN == 100000) begin
			miscompares++;
			finish_test;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// classic cycle: hold until ack, then release
	task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// ack is read as it stood at each rising edge
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		wb_we_i <= 0;
		@(posedge mclk);
	endtask
	task enter(input logic [31:0] ctl, input logic deep);
		wb(1, `ISS_STBY_MODE_OFS, {31'h0, deep}); // clock set before
		wb(1, `ISS_PROTECT_OFS, {24'h0, `ISS_PROTECT_KEY});
		wb(1, `ISS_STBY_CTRL_OFS, ctl);
		repeat (5) @(posedge mclk); // five idle slots after the store
	endtask
	task waitRun;
		n = 0;
		do begin @(posedge mclk); n++; end while (cpuClkEn !== 1);
		@(posedge mclk);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		wb(0, `ISS_STAB_SEL_OFS, 0);
		chk(rdat, {29'h0, `ISS_STAB_SEL_RST});
		wb(0, `ISS_STATUS_OFS, 0);
		chk(rdat, 32'h1);
		wb(0, 5'h14, 0);
		chk(rdat, 32'h0);
		wb(1, `ISS_STBY_CTRL_OFS, 32'h2);
		repeat (5) @(posedge mclk);
		chk(holdState, 0);
		$display("test regs done");
		// idle woken by pin, by low-voltage irq with ints off, by serial
		for (int i = 0; i < 3; i++) begin
			cfg <= (i == 0) ? 8'h7e : (i == 1) ? 8'h3f : 8'hff;
			enter(32'h2, 0);
			chk({holdState, cpuClkEn, oscEn, pllEn}, 4'hb);
			chk({periphClkEn, serialSlaveClkEn, powerOnClearEn}, 3'h3);
			externalIrqPins <= 6'h02;
			repeat (6) @(posedge mclk);
			chk(holdState, 1);
			case (i)
				0: externalIrqPins <= 6'h03;
				1: lowVoltageIrq <= 1;
				default: serialSlaveIrq <= 1;
			endcase
			waitRun;
			chk(n < 8, 1);
			externalIrqPins <= 6'h00;
			lowVoltageIrq <= 0;
			serialSlaveIrq <= 0;
			wb(0, `ISS_STBY_CTRL_OFS, 0);
			chk(rdat[1], 0);
		end
		chk({branchCnt, resumeCnt}, 16'h0102);
		$display("test idle done");
		enter(32'h12, 0);
		serialSlaveIrq <= 1;
		lowVoltageDetectorUsed <= 0;
		repeat (8) @(posedge mclk);
		chk(holdState, 1);
		chk(lowVoltageDetectorEn, 0);
		resetPin_n <= 0;
		repeat (4) @(posedge mclk);
		chk({sysReset, cpuClkEn}, 2'h2);
		resetPin_n <= 1;
		serialSlaveIrq <= 0;
		waitRun;
		chk(n >= 65536 && n < 65548, 1);
		wb(0, `ISS_STATUS_OFS, 0);
		chk(rdat[6:0], {`ISS_CAUSE_RST, 5'h01});
		$display("test reset done");
		wb(1, `ISS_STAB_SEL_OFS, 0); // shortest wait
		enter(32'h2, 1);
		chk({holdState, oscEn, pllEn, clkMonEn, intOscEn}, 5'h11);
		serialSlaveIrq <= 1;
		repeat (10) @(posedge mclk);
		chk(wdtCountEn, 1);
		waitRun;
		chk(n >= 4086 && n < 4098, 1);
		@(posedge mclk);
		chk(branchCnt, 8'h02);
		$display("test stop done");
		finish_test;
	end
endmodule
